/* File: gpanr_regs.sv */
// Behaviour
// [RQ1] Manual mode: control bit 11 forces MASTER when one, SLAVE when zero.
// [RQ2] Control bit 12 set selects manual role, clear selects automatic role.
// [RQ3] Control bits 11..8 wait for reset, restart, power-up or link loss.
// [RQ4] Control bit 10 is the automatic role preference, unused in manual.
// [RQ5] Control bits 9 and 8 advertise gigabit full, half duplex; reset one.
// [RQ6] Status bit 15 latches a role fault and clears when status is read.
// [RQ7] Status bit 14 shows the resolved role, one for MASTER.
// [RQ8] Status bits 13 and 12 show local and remote receiver health.
// [RQ9] Status bits 11 and 10 show partner gigabit full and half duplex.
// [RQ10] Status bits 7..0 count idle errors since the last read; reads clear.
// [RQ11] The idle error count stops at all ones and never wraps.
// [RQ12] Extended status reads zeros in bits 15,14 and ones in 13,12.
// [RQ13] Copper bit 15 stops link pulses; both resets clear it.
// [RQ14] Software writes only binary three into copper bits 14..12.
// [RQ15] Leaving power down performs a software reset and negotiation restart.
// [RQ16] The fault bit stays set after the fault ends until status is read; software reset and power-up also clear it.
//
// Purpose: Gigabit negotiation and copper control register bank.
// Assumes: Link-side status arrives on pins; events pass two flip-flops.
// Notes:   Read data stand one cycle after the read strobe.
`timescale 1ns/1ps
module gpanr_regs (
  // Clock and reset.
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  // Register port.
  input  wire logic [gpanr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [gpanr_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [gpanr_pkg::DATA_W-1:0] rdata_o,
  // Link-side status pins.
  input  wire logic                        power_down_i,
  input  wire logic                        link_up_i,
  input  wire logic                        ms_fault_i,
  input  wire logic                        ms_resolved_i,
  input  wire logic                        loc_rx_ok_i,
  input  wire logic                        rem_rx_ok_i,
  input  wire logic                        lp_fd_i,
  input  wire logic                        lp_hd_i,
  input  wire logic                        idle_err_i,
  // Applied configuration.
  output logic                             ms_manual_o,
  output logic                             ms_value_o,
  output logic                             port_type_o,
  output logic                             adv_fd_o,
  output logic                             adv_hd_o,
  output logic                             link_pulse_off_o,
  output logic                             sw_reset_o,
  output logic                             an_restart_o
);
  import gpanr_pkg::*;

  localparam int unsigned NSYNC = 9;

  if (DATA_W != $bits(EXT_STAT_VAL))
  begin : g_bad_data_w
    $error("Register words must match the status constants.");
  end

  if (ADDR_W != $bits(OFS_GIG_CTRL))
  begin : g_bad_addr_w
    $error("Register addresses must match the offset constants.");
  end

  typedef struct packed {
    logic        ms_manual;
    logic [3:0]  pend;
    logic [3:0]  act;
    logic        fault;
    logic [7:0]  idle_cnt;
    logic        pulse_off;
    logic [2:0]  rsvd;
    logic [15:0] rdata;
    logic        sw_reset;
    logic        an_restart;
  } gpanr_regs_st_t;

  gpanr_regs_st_t st_ff;
  gpanr_regs_st_t nxt_st;

  logic [NSYNC-1:0] pin_s;
  logic             pd_fall;
  logic             link_fall;
  logic             err_rise;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == CNT_MAX) ? CNT_MAX : v + 8'h01;
  endfunction : sat_inc

  gpanr_sync #(.W(NSYNC)) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .async_i ({idle_err_i, lp_hd_i, lp_fd_i, rem_rx_ok_i, loc_rx_ok_i,
               ms_resolved_i, ms_fault_i, link_up_i, power_down_i}),
    .sync_o  (pin_s)
  );

  gpanr_edge u_pd_edge (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .level_i (pin_s[0]),
    .rise_o  (),
    .fall_o  (pd_fall)
  );

  gpanr_edge u_link_edge (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .level_i (pin_s[1]),
    .rise_o  (),
    .fall_o  (link_fall)
  );

  gpanr_edge u_err_edge (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .level_i (pin_s[8]),
    .rise_o  (err_rise),
    .fall_o  ()
  );

  logic rd_stat;
  logic wr_gig;
  logic wr_cop;
  logic wr_host;
  logic apply;
  logic soft_rst;

  always_comb
  begin
    rd_stat  = rd_i && (addr_i == OFS_GIG_STAT);
    wr_gig   = wr_i && (addr_i == OFS_GIG_CTRL);
    wr_cop   = wr_i && (addr_i == OFS_COP_CTRL);
    wr_host  = wr_i && (addr_i == OFS_HOST_CTRL);
    soft_rst = wr_host && wdata_i[B_SW_RESET];
    nxt_st   = st_ff;
    nxt_st.sw_reset   = soft_rst || pd_fall;                   // [RQ15]
    nxt_st.an_restart = (wr_host && wdata_i[B_AN_RESTART])
                        || pd_fall;                            // [RQ15]
    apply = nxt_st.sw_reset || nxt_st.an_restart || link_fall; // [RQ3]
    if (wr_gig)
    begin
      nxt_st.ms_manual = wdata_i[B_MS_MANUAL];                    // [RQ2]
      nxt_st.pend = wdata_i[B_MS_VALUE:B_ADV_HD];                 // [RQ3]
    end
    if (apply)
    begin
      nxt_st.act = nxt_st.pend;                                   // [RQ3]
    end
    if (wr_cop)
    begin
      nxt_st.pulse_off = wdata_i[B_LINK_PULSE_OFF];               // [RQ13]
      nxt_st.rsvd = wdata_i[B_RSVD_HI:B_RSVD_LO];                 // [RQ14]
    end
    if (soft_rst || pd_fall)
    begin
      nxt_st.pulse_off = 1'b0;                                    // [RQ13]
      nxt_st.fault = 1'b0;
      nxt_st.idle_cnt = 8'h00;
    end
    if (rd_stat)
    begin
      nxt_st.fault = 1'b0;                                        // [RQ6]
      nxt_st.idle_cnt = 8'h00;                                    // [RQ10]
    end
    if (pin_s[2])
    begin
      nxt_st.fault = 1'b1;                                        // [RQ16]
    end
    if (err_rise)
    begin
      nxt_st.idle_cnt = sat_inc(nxt_st.idle_cnt);                 // [RQ11]
    end
    nxt_st.rdata = ZERO16;
    if (rd_i)
    begin
      case (addr_i)
        OFS_GIG_CTRL:
          nxt_st.rdata = {3'h0, st_ff.ms_manual, st_ff.pend, 8'h00};
        OFS_GIG_STAT:
          nxt_st.rdata = {st_ff.fault, pin_s[3],     // [RQ7]
                          pin_s[4], pin_s[5],        // [RQ8]
                          pin_s[6], pin_s[7], 2'h0,  // [RQ9]
                          st_ff.idle_cnt};           // [RQ10]
        OFS_EXT_STAT:
          nxt_st.rdata = EXT_STAT_VAL;                             // [RQ12]
        OFS_COP_CTRL:
          nxt_st.rdata = {st_ff.pulse_off, st_ff.rsvd, 12'h000};
        default:
          nxt_st.rdata = ZERO16;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '{ms_manual: 1'b0, pend: PEND_RST, act: PEND_RST,  // [RQ5]
                 fault: 1'b0, idle_cnt: 8'h00, pulse_off: 1'b0,
                 rsvd: COP_RSVD_RST, rdata: ZERO16, sw_reset: 1'b0,
                 an_restart: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o          = st_ff.rdata;
  assign ms_manual_o      = st_ff.ms_manual;                       // [RQ2]
  assign ms_value_o       = st_ff.act[3];                          // [RQ1]
  assign port_type_o      = st_ff.act[2];                          // [RQ4]
  assign adv_fd_o         = st_ff.act[1];                          // [RQ5]
  assign adv_hd_o         = st_ff.act[0];                          // [RQ5]
  assign link_pulse_off_o = st_ff.pulse_off;                       // [RQ13]
  assign sw_reset_o       = st_ff.sw_reset;
  assign an_restart_o     = st_ff.an_restart;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  AST_READ_CLR: assert property ( // [RQ6]
    rd_stat && !pin_s[2] |=> !st_ff.fault)
    else $error("Fault bit not cleared by read.");

  AST_FAULT_SET: assert property ( // [RQ6]
    pin_s[2] |=> st_ff.fault)
    else $error("Fault bit not latched.");

  AST_FAULT_HOLD: assert property ( // [RQ16]
    st_ff.fault && !rd_stat && !soft_rst && !pd_fall
    |=> st_ff.fault)
    else $error("Fault bit dropped without read.");

  AST_CNT_INC: assert property ( // [RQ10]
    err_rise && !rd_stat && !soft_rst && !pd_fall
    && st_ff.idle_cnt != CNT_MAX
    |=> st_ff.idle_cnt == $past(st_ff.idle_cnt) + 8'h01)
    else $error("Idle error not counted.");

  AST_CNT_CLR: assert property ( // [RQ10]
    rd_stat && !err_rise |=> st_ff.idle_cnt == 8'h00)
    else $error("Idle counter not cleared by read.");

  AST_SATURATE: assert property ( // [RQ11]
    st_ff.idle_cnt == CNT_MAX && !rd_stat && !soft_rst && !pd_fall
    |=> st_ff.idle_cnt == CNT_MAX)
    else $error("Idle counter wrapped.");

  AST_MANUAL: assert property ( // [RQ2]
    wr_gig |=> ms_manual_o == $past(wdata_i[B_MS_MANUAL]))
    else $error("Manual role select not taken.");

  AST_PENDING: assert property ( // [RQ3]
    wr_gig && !apply |=> $stable(st_ff.act))
    else $error("Pending setting applied early.");

  AST_LINK_APPLY: assert property ( // [RQ3]
    link_fall && !wr_gig |=> st_ff.act == st_ff.pend)
    else $error("Link loss did not apply settings.");

  AST_SW_APPLY: assert property ( // [RQ1] [RQ4] [RQ5]
    soft_rst
    |=> {ms_value_o, port_type_o, adv_fd_o, adv_hd_o} == st_ff.pend)
    else $error("Software reset did not apply settings.");

  AST_APPLY: assert property ( // [RQ15]
    pd_fall && !wr_gig |=> st_ff.act == st_ff.pend)
    else $error("Power-up did not apply settings.");

  AST_PWR_UP: assert property ( // [RQ15]
    pd_fall |=> sw_reset_o && an_restart_o && !link_pulse_off_o)
    else $error("Power-up did not reset and restart.");

  AST_PULSE_RST: assert property ( // [RQ13]
    soft_rst |=> !link_pulse_off_o)
    else $error("Link pulse disable survived reset.");

  AST_EXT: assert property ( // [RQ12]
    rd_i && addr_i == OFS_EXT_STAT |=> rdata_o == EXT_STAT_VAL)
    else $error("Extended status wrong.");

  AST_ROLE: assert property ( // [RQ7]
    rd_stat |=> rdata_o[B_MS_RES] == $past(pin_s[3]))
    else $error("Resolved role misreported.");

  AST_RX_OK: assert property ( // [RQ8]
    rd_stat |=> rdata_o[B_LOC_RX_OK] == $past(pin_s[4])
    && rdata_o[B_REM_RX_OK] == $past(pin_s[5]))
    else $error("Receiver health misreported.");

  AST_PARTNER: assert property ( // [RQ9]
    rd_stat |=> rdata_o[B_LP_FD] == $past(pin_s[6])
    && rdata_o[B_LP_HD] == $past(pin_s[7]))
    else $error("Partner abilities misreported.");

  COV_FAULT: cover property (st_ff.fault ##1 rd_stat);
  COV_SAT: cover property (st_ff.idle_cnt == CNT_MAX);
  COV_LINK_APPLY: cover property (wr_gig ##[1:20] link_fall);
  COV_SW_RESET: cover property (soft_rst);
  COV_PWR_UP: cover property (pd_fall);
endmodule : gpanr_regs

/* File: gpanr_pkg.sv */
// Purpose: Shared constants for the gigabit negotiation register bank.
// Assumes: Registers are 16 bits wide at 5-bit management addresses.
// Notes:   Field positions and reset values are named here only.
package gpanr_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  localparam logic [4:0] OFS_GIG_CTRL  = 5'h09;
  localparam logic [4:0] OFS_GIG_STAT  = 5'h0A;
  localparam logic [4:0] OFS_EXT_STAT  = 5'h0F;
  localparam logic [4:0] OFS_COP_CTRL  = 5'h10;
  localparam logic [4:0] OFS_HOST_CTRL = 5'h1C;

  localparam int unsigned B_MS_MANUAL  = 12;
  localparam int unsigned B_MS_VALUE   = 11;
  localparam int unsigned B_PORT_TYPE  = 10;
  localparam int unsigned B_ADV_FD     = 9;
  localparam int unsigned B_ADV_HD     = 8;
  localparam int unsigned B_MS_FAULT   = 15;
  localparam int unsigned B_MS_RES     = 14;
  localparam int unsigned B_LOC_RX_OK  = 13;
  localparam int unsigned B_REM_RX_OK  = 12;
  localparam int unsigned B_LP_FD      = 11;
  localparam int unsigned B_LP_HD      = 10;
  localparam int unsigned B_LINK_PULSE_OFF = 15;
  localparam int unsigned B_RSVD_HI    = 14;
  localparam int unsigned B_RSVD_LO    = 12;
  localparam int unsigned B_SW_RESET   = 1;
  localparam int unsigned B_AN_RESTART = 0;

  localparam logic [15:0] GIG_CTRL_RST = 16'h0300;
  localparam logic [3:0]  PEND_RST     = 4'h3;
  localparam logic [15:0] EXT_STAT_VAL = 16'h3000;
  localparam logic [2:0]  COP_RSVD_RST = 3'h3;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;

endpackage : gpanr_pkg

/* File: gpanr_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of pin levels.
// Assumes: Inputs are asynchronous levels.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module gpanr_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  // Levels.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gpanr_sync_st_t;

  gpanr_sync_st_t st_ff;
  gpanr_sync_st_t nxt_st;

  if (W < 1)
  begin : g_bad_width
    $error("Width must be at least one.");
  end

  always_comb
  begin
    nxt_st.meta = async_i;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.sync;
endmodule : gpanr_sync

/* File: gpanr_edge.sv */
// Purpose: Rising and falling edge pulses of a synchronised level.
// Assumes: Input is already in the clock domain.
// Notes:   Pulses last one cycle.
`timescale 1ns/1ps
module gpanr_edge (
  // Clock and reset.
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  // Level and pulses.
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic prev;
  } gpanr_edge_st_t;

  gpanr_edge_st_t st_ff;
  gpanr_edge_st_t nxt_st;

  always_comb
  begin
    nxt_st.prev = level_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rise_o = level_i & ~st_ff.prev;
  assign fall_o = ~level_i & st_ff.prev;
endmodule : gpanr_edge

/* File: gpanr_link_model.sv */
// Purpose: Link-side model that drives the transceiver status pins.
// Assumes: Pins change by non-blocking assignment after a rising edge.
// Notes:   Each idle error is a pulse two cycles high and one cycle low.
`timescale 1ns/1ps
module gpanr_link_model (
  // Clock.
  input  wire logic       clock_i,
  // Status pins.
  output logic      [7:0] pins_o,
  output logic            idle_err_o
);
  initial pins_o = 8'h00;
  initial idle_err_o = 1'b0;

  task automatic set_pins(input logic [7:0] v);
    @(posedge clock_i);
    pins_o <= v;
  endtask : set_pins

  task automatic burst(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      idle_err_o <= 1'b1;
      repeat (2) @(posedge clock_i);
      idle_err_o <= 1'b0;
    end
  endtask : burst
endmodule : gpanr_link_model

/* File: test_gpanr_regs.sv */
// Purpose: Self-checking bench for the negotiation register bank.
// Assumes: Pin order is power down, link up, fault, then status bits.
// Notes:   Random stimulus comes from a fixed seed.
`timescale 1ns/1ps
module test_gpanr_regs;
  import gpanr_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [4:0]  addr_i  = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [15:0] rdata_o, d, w;
  logic [7:0]  pins, p;
  logic [4:0]  prev;
  logic        idle_err, ms_manual_o, ms_value_o, port_type_o;
  logic        adv_fd_o, adv_hd_o, link_pulse_off_o, sw_reset_o;
  logic        an_restart_o;
  int          mismatches = 0;
  int          checks = 0;
  int          n_sw = 0;
  int          n_an = 0;
  int          n, bs, ba;

  gpanr_link_model u_link (.clock_i(clock_i), .pins_o(pins),
    .idle_err_o(idle_err));
  gpanr_regs u_gpanr_regs (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .power_down_i(pins[7]), .link_up_i(pins[6]),
    .ms_fault_i(pins[5]), .ms_resolved_i(pins[4]), .loc_rx_ok_i(pins[3]),
    .rem_rx_ok_i(pins[2]), .lp_fd_i(pins[1]), .lp_hd_i(pins[0]),
    .idle_err_i(idle_err), .ms_manual_o(ms_manual_o),
    .ms_value_o(ms_value_o), .port_type_o(port_type_o),
    .adv_fd_o(adv_fd_o), .adv_hd_o(adv_hd_o),
    .link_pulse_off_o(link_pulse_off_o), .sw_reset_o(sw_reset_o),
    .an_restart_o(an_restart_o));

  always #2.5 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    n_sw <= n_sw + int'(sw_reset_o === 1'b1);
    n_an <= n_an + int'(an_restart_o === 1'b1);
  end

  function automatic logic [15:0] cfg();
    return {11'h0, ms_manual_o, ms_value_o, port_type_o, adv_fd_o, adv_hd_o};
  endfunction : cfg

  function automatic logic [7:0] sat(input int k);
    return (k > 255) ? 8'hFF : 8'(k);
  endfunction : sat

  function automatic logic [15:0] exp_stat(input logic [7:0] q,
    input logic f, input logic [7:0] c);
    return {f, q[4:0], 2'b00, c};
  endfunction : exp_stat

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask : rd

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    final_report();
  end

  initial
  begin
    n = $urandom(65520);
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(OFS_GIG_CTRL, d);
    chk("gig_ctrl", 16'h0300, d);
    chk("adv", 16'h0003, cfg());
    wr(OFS_EXT_STAT, 16'h0000);
    rd(OFS_EXT_STAT, d);
    chk("ext_stat", 16'h3000, d);
    rd(OFS_COP_CTRL, d);
    chk("cop_ctrl", 16'h3000, d & 16'hF000);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, d);
    chk("unmapped", 16'h0000, d);
    prev = 5'h03;
    for (int e = 0; e < 4; e++)
    begin
      w = 16'($urandom) & 16'h1F00;
      wr(OFS_COP_CTRL, 16'hB000);
      wr(OFS_GIG_CTRL, w);
      repeat (2) @(posedge clock_i);
      #1 chk("pend", {11'h0, w[12], prev[3:0]}, cfg());
      chk("pulse_off", 16'h0001, 16'(link_pulse_off_o));
      bs = n_sw;
      ba = n_an;
      if (e < 2)
        wr(OFS_HOST_CTRL, 16'(2 - e));
      else
      begin
        u_link.set_pins(8'h80 >> (e - 2));
        repeat (4) @(posedge clock_i);
        u_link.set_pins(8'h00);
      end
      repeat (6) @(posedge clock_i);
      #1 chk("apply", {11'h0, w[12:8]}, cfg());
      chk("pulses", 16'((8'h36 >> (2 * e)) & 8'h03),
        16'((n_sw - bs) * 2 + (n_an - ba)));
      chk("pulse_clr", 16'(e % 2), 16'(link_pulse_off_o));
      prev = w[12:8];
    end
    p = 8'($urandom) & 8'h1F;
    u_link.set_pins(p | 8'h20);
    repeat (4) @(posedge clock_i);
    u_link.set_pins(p);
    repeat (4) @(posedge clock_i);
    rd(OFS_GIG_STAT, d);
    chk("fault", exp_stat(p, 1'b1, 8'h00), d);
    rd(OFS_GIG_STAT, d);
    chk("fault_clr", exp_stat(p, 1'b0, 8'h00), d);
    n = 1 + int'($urandom % 40);
    u_link.burst(n);
    repeat (4) @(posedge clock_i);
    rd(OFS_GIG_STAT, d);
    chk("idle", exp_stat(p, 1'b0, sat(n)), d);
    rd(OFS_GIG_STAT, d);
    chk("idle_clr", exp_stat(p, 1'b0, 8'h00), d);
    u_link.burst(260);
    repeat (4) @(posedge clock_i);
    rd(OFS_GIG_STAT, d);
    chk("idle_sat", exp_stat(p, 1'b0, sat(260)), d);
    wr(OFS_COP_CTRL, 16'hB000);
    wr(OFS_GIG_CTRL, 16'h1C00);
    u_link.burst(3);
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(OFS_COP_CTRL, d);
    chk("hw_rst_cop", 16'h3000, d);
    rd(OFS_GIG_CTRL, d);
    chk("hw_rst_gig", 16'h0300, d);
    chk("hw_rst_adv", 16'h0003, cfg());
    repeat (4) @(posedge clock_i);
    rd(OFS_GIG_STAT, d);
    chk("hw_rst_stat", exp_stat(p, 1'b0, 8'h00), d);
    final_report();
  end
endmodule : test_gpanr_regs
